// File: src/cdr_clock_reset.sv
// Divide-by-two system clock generator with reset request synchroniser.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - System clock is input clock halved, 50 percent.
// - System clock toggles only on input clock edges.
// - Clock runs in reset, hold, idle; stops powerdown.
// - Input clock feeds divider directly, any duty.
// - Internal reset comes from synchronised reset request.
// - Cold powerup: pins reset within 28 input periods.
// - Warm reset: pins reset shortly after request falls.
// - Request rising edge makes phase realign pulse.
// - Request seen high, clock high: hold low two cycles.
// - Reset indication released second system clock fall.
// - First bus activity seven output periods after realign edge.
// - Bus request during reset granted when start count ends.
// - Idle bus: grant follows request after synchronising.
module cdr_clock_reset (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic reset_request_n_in,
  input  wire logic bus_request_in,
  input  wire logic powerdown_in,
  output var  logic system_clock_out,
  output var  logic reset_indication_out,
  output var  logic pins_in_reset_out,
  output var  logic phase_realign_pulse_out,
  output var  logic bus_start_out,
  output var  logic bus_grant_ack_out
);

  cdr_pkg::cdr_state_t state_q;
  logic                rreq_s1_q;
  logic                rreq_s2_q;
  logic                rreq_prev_q;
  logic                breq_s1_q;
  logic                breq_s2_q;
  logic                pdn_s1_q;
  logic                pdn_s2_q;
  logic                clk_q;
  logic [3:0]          skip_q;
  logic [3:0]          start_q;
  logic [1:0]          falls_q;
  logic                rst_ind_q;
  logic                pins_rst_q;
  logic                realign_q;
  logic                bus_start_q;
  logic                grant_q;
  logic                rise;
  logic                fall_out;

  //////////////////////////////////////////////////////////////////////////////
  // Shared helpers.

  // Steps a cycle counter towards zero and parks it there.
  function automatic logic [3:0] count_down(input logic [3:0] value);
    count_down = (value != 4'h0) ? value - 4'h1 : 4'h0;
  endfunction

  // Tells whether the system clock fall at this edge completes the release count.
  function automatic logic last_fall(input logic [1:0] falls, input logic fall_now);
    last_fall = fall_now && (falls + 2'h1 == cdr_pkg::RELEASE_FALLS);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  // The request history starts at the asserted level, so a pin already held
  // low through power-up cannot look like a release edge.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rreq_s1_q   <= cdr_pkg::SYNC_RST_VAL;
      rreq_s2_q   <= cdr_pkg::SYNC_RST_VAL;
      rreq_prev_q <= cdr_pkg::SYNC_RST_VAL;
    end else begin
      rreq_s1_q   <= reset_request_n_in;
      rreq_s2_q   <= rreq_s1_q;
      rreq_prev_q <= rreq_s2_q;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      breq_s1_q <= 1'h0;
      breq_s2_q <= 1'h0;
      pdn_s1_q  <= 1'h0;
      pdn_s2_q  <= 1'h0;
    end else begin
      breq_s1_q <= bus_request_in;
      breq_s2_q <= breq_s1_q;
      pdn_s1_q  <= powerdown_in;
      pdn_s2_q  <= pdn_s1_q;
    end
  end

  // A release edge of the synchronised request, and a system clock fall due at this edge.
  assign rise     = rreq_s2_q & ~rreq_prev_q;
  assign fall_out = clk_q & (skip_q == 4'h0) & ~pdn_s2_q;

  //////////////////////////////////////////////////////////////////////////////
  // Divide-by-two clock with beat skip on realignment.

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      clk_q  <= 1'h0;
      skip_q <= 4'h0;
    end else if (rise && clk_q) begin
      clk_q  <= 1'h0;
      skip_q <= cdr_pkg::SKIP_IN_CYCLES - 4'h1;
    end else if (skip_q != 4'h0) begin
      // Skipped beat: the clock stays low while the phases line up again.
      skip_q <= count_down(skip_q);
    end else if (!pdn_s2_q) begin
      // Powerdown stops the toggling; a skip countdown or a realignment still acts.
      clk_q <= ~clk_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset sequencing.

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= cdr_pkg::ST_RESET;
      falls_q <= 2'h0;
      start_q <= 4'h0;
    end else if (!rreq_s2_q) begin
      // A low request restarts the sequence from any state.
      state_q <= cdr_pkg::ST_RESET;
      falls_q <= 2'h0;
      start_q <= 4'h0;
    end else begin
      case (state_q)
        cdr_pkg::ST_RESET: begin
          // The bus start count is loaded on the realignment edge.
          if (rise) begin
            state_q <= cdr_pkg::ST_REALIGN;
            start_q <= cdr_pkg::BUS_START_CYCLES - 4'h1;
          end
        end
        cdr_pkg::ST_REALIGN: begin
          // The bus start count keeps running while the release falls are counted.
          start_q <= count_down(start_q);
          if (fall_out) begin
            falls_q <= falls_q + 2'h1;
            if (last_fall(falls_q, fall_out)) begin
              state_q <= cdr_pkg::ST_WAIT;
            end
          end
        end
        cdr_pkg::ST_WAIT: begin
          // Hold here until the bus start count has run out.
          if (start_q == 4'h0) begin
            state_q <= cdr_pkg::ST_RUN;
          end else begin
            start_q <= count_down(start_q);
          end
        end
        cdr_pkg::ST_RUN: begin
          state_q <= cdr_pkg::ST_RUN;
        end
        default: begin
          state_q <= cdr_pkg::ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pins_rst_q <= 1'h1;
      rst_ind_q  <= 1'h1;
      realign_q  <= 1'h0;
    end else begin
      pins_rst_q <= ~rreq_s2_q | (state_q == cdr_pkg::ST_RESET) |
                    (state_q == cdr_pkg::ST_REALIGN);
      realign_q  <= rise;
      if (!rreq_s2_q) begin
        rst_ind_q <= 1'h1;
      end else if (state_q == cdr_pkg::ST_REALIGN && last_fall(falls_q, fall_out)) begin
        rst_ind_q <= 1'h0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus start and hold acknowledge.

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bus_start_q <= 1'h0;
      grant_q     <= 1'h0;
    end else begin
      // Bus start is a single-cycle pulse when no master holds the bus.
      bus_start_q <= (state_q == cdr_pkg::ST_WAIT) && (start_q == 4'h0) && !breq_s2_q;
      // A new reset request drops the grant at once, so the grant never
      // overlaps the reset indication.
      if (rreq_s2_q &&
          (state_q == cdr_pkg::ST_RUN ||
           (state_q == cdr_pkg::ST_WAIT && start_q == 4'h0))) begin
        grant_q <= breq_s2_q;
      end else begin
        grant_q <= 1'h0;
      end
    end
  end

  // Every output is a flop copied straight to its port.
  always_comb begin
    system_clock_out        = clk_q;
    reset_indication_out    = rst_ind_q;
    pins_in_reset_out       = pins_rst_q;
    phase_realign_pulse_out = realign_q;
    bus_start_out           = bus_start_q;
    bus_grant_ack_out       = grant_q;
  end

endmodule // cdr_clock_reset

`default_nettype wire

// File: src/cdr_pkg.sv
// Constants shared by the clock divider and reset synchroniser.
package cdr_pkg;
  localparam int unsigned CLK_IN_HZ         = 50000000;
  localparam int unsigned IN_PER_OUT        = 2;
  localparam int unsigned SKIP_OUT_CYCLES   = 2;
  localparam logic [3:0]  SKIP_IN_CYCLES    = 4'(SKIP_OUT_CYCLES * IN_PER_OUT);
  localparam int unsigned BUS_START_PERIODS = 7;
  localparam logic [3:0]  BUS_START_CYCLES  = 4'(BUS_START_PERIODS * IN_PER_OUT);
  localparam logic [1:0]  RELEASE_FALLS     = 2'h2;
  localparam int unsigned COLD_PIN_MAX      = 28;
  localparam logic        SYNC_RST_VAL      = 1'h0;

  typedef enum logic [3:0] {
    ST_RESET   = 4'h1,
    ST_REALIGN = 4'h2,
    ST_WAIT    = 4'h4,
    ST_RUN     = 4'h8
  } cdr_state_t;
endpackage

// File: sim/cdr_src_model.sv
// Model of the reset source and the bus-requesting master.
`timescale 1ns/1ns
`default_nettype none
module cdr_src_model (
  input  wire logic clk_in,
  output var  logic req_n_out,
  output var  logic breq_out
);
  initial begin
    req_n_out = 1'h0;
    breq_out  = 1'h0;
  end
  task drive(input logic r, input logic b);
    @(posedge clk_in);
    req_n_out <= r;
    breq_out  <= b;
  endtask
endmodule // cdr_src_model
`default_nettype wire

// File: sim/cdr_clock_reset_chk.sv
// Assertions on the ports of the clock divider and reset synchroniser.
`timescale 1ns/1ns
`default_nettype none
module cdr_chk (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic reset_request_n_in,
  input wire logic bus_request_in,
  input wire logic powerdown_in,
  input wire logic system_clock_out,
  input wire logic reset_indication_out,
  input wire logic pins_in_reset_out,
  input wire logic phase_realign_pulse_out,
  input wire logic bus_start_out,
  input wire logic bus_grant_ack_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rel;
    $rose(reset_request_n_in) ##3 phase_realign_pulse_out;
  endsequence
  AST_HIGH1: assert property (disable iff (rst_in || powerdown_in)
    $rose(system_clock_out) |=> !system_clock_out)
    else $error("clock high too long");
  AST_LOWMAX: assert property (disable iff (rst_in || powerdown_in)
    $fell(system_clock_out) |-> ##[1:5] system_clock_out)
    else $error("clock low too long");
  AST_PDSTOP: assert property (powerdown_in [*4] |-> $stable(system_clock_out))
    else $error("clock runs in powerdown");
  AST_PINS: assert property ($fell(reset_request_n_in) |-> ##3 pins_in_reset_out)
    else $error("pins not in reset");
  AST_RESIND: assert property (!reset_request_n_in [*3] |=> reset_indication_out)
    else $error("reset indication missing");
  AST_REALIGN: assert property ($rose(reset_request_n_in) |-> ##3 phase_realign_pulse_out)
    else $error("no realign pulse");
  AST_PULSE1: assert property (phase_realign_pulse_out |=> !phase_realign_pulse_out)
    else $error("realign pulse too long");
  AST_START: assert property (s_rel |-> ##[8:20] (bus_start_out || bus_grant_ack_out))
    else $error("bus start missing");
  AST_EARLY: assert property (s_rel |=> !bus_start_out [*6])
    else $error("bus start too early");
  AST_GRANT: assert property (bus_grant_ack_out |-> !reset_indication_out)
    else $error("grant during reset");
endmodule // cdr_chk
bind cdr_clock_reset cdr_chk chk_i (
  .ref_clk_in              (ref_clk_in),
  .rst_in                  (rst_in),
  .reset_request_n_in      (reset_request_n_in),
  .bus_request_in          (bus_request_in),
  .powerdown_in            (powerdown_in),
  .system_clock_out        (system_clock_out),
  .reset_indication_out    (reset_indication_out),
  .pins_in_reset_out       (pins_in_reset_out),
  .phase_realign_pulse_out (phase_realign_pulse_out),
  .bus_start_out           (bus_start_out),
  .bus_grant_ack_out       (bus_grant_ack_out)
);
`default_nettype wire

// File: sim/clock_divide_reset_sync_bench.sv
// Self-checking bench for the clock divider and reset synchroniser.
`timescale 1ns/1ns
`default_nettype none
module clock_divide_reset_sync_bench;
  logic      clk, rst, pd, sc, ri, pr, rp, bs, ga;
  wire logic req_n, breq;
  int        n_fail, checks, i;
  cdr_src_model src (.clk_in(clk), .req_n_out(req_n), .breq_out(breq));
  cdr_clock_reset uut (.ref_clk_in(clk), .rst_in(rst), .reset_request_n_in(req_n),
    .bus_request_in(breq), .powerdown_in(pd), .system_clock_out(sc),
    .reset_indication_out(ri), .pins_in_reset_out(pr), .phase_realign_pulse_out(rp),
    .bus_start_out(bs), .bus_grant_ack_out(ga));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  task chk(input string n, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %b got %b", n, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task conclude;
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task t_release(input logic b);
    src.drive(1'h1, b);
    cyc(3);
    chk("realign", 1'h1, rp);
    for (i = 0; i < 30 && ga !== 1'h1 && bs !== 1'h1; i++) cyc(1);
    if (i >= 30) begin
      n_fail++;
      conclude;
    end
    chk("reset_ind", 1'h0, ri);
    chk("pins_free", 1'h0, pr);
    chk("grant", b, ga);
    chk("start", !b, bs);
  endtask
  task t_divide;
    logic p;
    for (int k = 0; k < 6; k++) begin
      p = sc;
      cyc(1);
      chk("clk", !p, sc);
    end
  endtask
  task t_grant;
    src.drive(1'h1, 1'h1);
    cyc(2);
    chk("grant_early", 1'h0, ga);
    cyc(1);
    chk("grant", 1'h1, ga);
    src.drive(1'h1, 1'h0);
    cyc(2);
  endtask
  task t_power;
    logic v;
    @(posedge clk);
    pd <= 1'h1;
    cyc(2);
    v = sc;
    for (int k = 0; k < 4; k++) begin
      cyc(1);
      chk("clk_stopped", v, sc);
    end
    @(posedge clk);
    pd <= 1'h0;
    cyc(3);
    t_divide;
  endtask
  task t_warm;
    src.drive(1'h0, 1'h1);
    cyc(3);
    chk("pins", 1'h1, pr);
    chk("reset_ind", 1'h1, ri);
    t_divide;
    t_release(1'h1);
    src.drive(1'h1, 1'h0);
  endtask
  initial begin
    n_fail = 0;
    checks = 0;
    pd = 1'h0;
    rst = 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    cyc(4);
    chk("pins", 1'h1, pr);
    t_release(1'h0);
    t_divide;
    t_grant;
    t_power;
    t_warm;
    conclude;
  end
endmodule // clock_divide_reset_sync_bench
`default_nettype wire
